// File: ltg_defines.svh
// constants for the load transient generator: encodings, reset values, limits
// assumes a 100 mhz system clock
`ifndef LTG_DEFINES_SVH
`define LTG_DEFINES_SVH
`define LTG_CLK_HZ            100000000
`define LTG_SP_W              16
`define LTG_MODE_W            2
`define LTG_MODE_FREE         2'h0
`define LTG_MODE_ONESHOT      2'h1
`define LTG_MODE_SWAP         2'h2
`define LTG_MODE_TABLE        2'h3
`define LTG_MODE_RST          2'h3
// repeat total: 1..9999, zero means unlimited
`define LTG_RPT_W             14
`define LTG_RPT_MIN           14'h0001
`define LTG_RPT_MAX           14'h270f
`define LTG_RPT_RST           14'h0001
// high fraction in tenths of a percent: 1.8 .. 98.2, 50 after reset
`define LTG_FRAC_W            10
`define LTG_FRAC_MIN          10'h012
`define LTG_FRAC_MAX          10'h3d6
`define LTG_FRAC_RST          10'h1f4
`define LTG_FRAC_FULL         1000
// frequency in quarter hertz: 0.25 .. 10000 hz, maximum after reset
`define LTG_FREQ_W            16
`define LTG_FREQ_MIN          16'h0001
`define LTG_FREQ_MAX          16'h9c40
`define LTG_FREQ_RST          16'h9c40
// pulse duration in units of 100 us: 0.0001 .. 268435 s, 0.0005 s after reset
`define LTG_DUR_UNIT_NS       100000
`define LTG_DUR_UNIT_CYC      (`LTG_DUR_UNIT_NS / 10)
`define LTG_DUR_W             32
`define LTG_DUR_MIN           32'h00000001
`define LTG_DUR_MAX           32'h9fffee30
`define LTG_DUR_RST           32'h00000005
// longest pulse is 268435 s of 10 ns cycles, which needs more than 40 bits
`define LTG_CNT_W             48
`define LTG_THR_W             16
`define LTG_THR_RST           16'h0000
`endif

// File: ltg_pkg.sv
// types shared by the transient generator modules
package ltg_pkg;
  typedef logic [1:0] ltg_mode_t;
  typedef enum logic [1:0] {
    LTG_IDLE  = 2'b00,
    LTG_HIGH  = 2'b01,
    LTG_LOW   = 2'b10
  } ltg_state_e;
endpackage

// File: ltg_cfg_if.sv
// carries clamped settings from the settings module to the generator core
// assumes both ends share i_sys_clk
`timescale 1ns/1ps
`include "ltg_defines.svh"
interface ltg_cfg_if;
  logic [`LTG_MODE_W-1:0] mode;
  logic [`LTG_RPT_W-1:0]  rpt;
  logic [`LTG_FRAC_W-1:0] frac;
  logic [`LTG_FREQ_W-1:0] freq;
  logic [`LTG_DUR_W-1:0]  dur;
  logic [`LTG_THR_W-1:0]  thr;
  logic                   slope_fall;
  modport src (output mode, rpt, frac, freq, dur, thr, slope_fall);
  modport dst (input  mode, rpt, frac, freq, dur, thr, slope_fall);
endinterface

// File: ltg_settings.sv
// settings store: takes writes from the command interpreter and clamps repeat, fraction, frequency and duration
// assumes writes come from logic on i_sys_clk
`timescale 1ns/1ps
`include "ltg_defines.svh"
module ltg_settings (
  input  wire logic                   i_sys_clk,   // system clock
  input  wire logic                   i_arst_n,    // async reset
  input  wire logic                   i_wr,        // write strobe
  input  wire logic [2:0]             i_sel,       // which setting
  input  wire logic [31:0]            i_wdata,     // write value
  ltg_cfg_if.src                      cfg          // clamped settings
);
  import ltg_pkg::*;

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // clamp candidates
  wire logic [31:0] rpt_c  = (i_wdata == 32'h0) ? 32'h0 : clamp(i_wdata, 32'(`LTG_RPT_MIN), 32'(`LTG_RPT_MAX));
  wire logic [31:0] frac_c = clamp(i_wdata, 32'(`LTG_FRAC_MIN), 32'(`LTG_FRAC_MAX));
  wire logic [31:0] freq_c = clamp(i_wdata, 32'(`LTG_FREQ_MIN), 32'(`LTG_FREQ_MAX));
  wire logic [31:0] dur_c  = clamp(i_wdata, `LTG_DUR_MIN, `LTG_DUR_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // setting registers, reset to documented defaults
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg.mode       <= `LTG_MODE_RST;
      cfg.rpt        <= `LTG_RPT_RST;
      cfg.frac       <= `LTG_FRAC_RST;
      cfg.freq       <= `LTG_FREQ_RST;
      cfg.dur        <= `LTG_DUR_RST;
      cfg.thr        <= `LTG_THR_RST;
      cfg.slope_fall <= 1'b0;
    end else if (i_wr) begin
      case (i_sel)
        3'h0: cfg.mode       <= i_wdata[`LTG_MODE_W-1:0];
        3'h1: cfg.rpt        <= rpt_c[`LTG_RPT_W-1:0];
        3'h2: cfg.frac       <= frac_c[`LTG_FRAC_W-1:0];
        3'h3: cfg.freq       <= freq_c[`LTG_FREQ_W-1:0];
        3'h4: cfg.dur        <= dur_c;
        3'h5: cfg.thr        <= i_wdata[`LTG_THR_W-1:0];
        3'h6: cfg.slope_fall <= i_wdata[0];
        default: ;
      endcase
    end
  end
endmodule

// File: ltg_top.sv
// load transient generator: picks main, alternate or table setpoint for the load
// stage, plus the acquisition trigger gate; settings come as plain ports
// Notes on behaviour
// - alternate setpoint kept; main never modified
// - four modes, settable and read back
// - free mode: continuous main/alternate pulse train
// - one-shot: one alternate pulse per trigger
// - swap mode: each trigger flips setpoint
// - table mode selected; default after reset
// - repeat total 1..9999 or unlimited, reset one
// - high fraction 1.8..98.2 percent, reset 50
// - frequency 0.25..10000 hz, reset maximum
// - pulse duration 0.0001..268435 s, reset 0.0005
// - immediate trigger bypasses selected source
// - completion clears waiting-for-trigger flag
// - current compared to threshold, reset minimum
// - level trigger slope rising or falling
`timescale 1ns/1ps
`include "ltg_defines.svh"
module ltg_top (
  input  wire logic                   i_sys_clk,     // 100 mhz clock
  input  wire logic                   i_arst_n,      // async reset, low
  input  wire logic                   i_wr,          // setting write strobe
  input  wire logic [2:0]             i_sel,         // setting select
  input  wire logic [31:0]            i_wdata,       // setting value
  input  wire logic [`LTG_SP_W-1:0]   i_main_sp,     // main setpoint
  input  wire logic [`LTG_SP_W-1:0]   i_alt_sp,      // alternate_setpoint
  input  wire logic [`LTG_SP_W-1:0]   i_table_sp,    // setpoint from table engine
  input  wire logic                   i_tran_trig,   // transient trigger pulse
  input  wire logic                   i_run,         // start free mode pulse
  input  wire logic                   i_acq_arm,     // arm acquisition pulse
  input  wire logic                   i_acq_imm,     // immediate trigger pulse
  input  wire logic                   i_acq_src_lvl, // source is current level
  input  wire logic                   i_acq_src_trg, // other selected source fired
  input  wire logic [`LTG_THR_W-1:0]  i_meas_cur,    // measured current
  output ltg_pkg::ltg_mode_t          o_mode,        // mode read back
  output logic [`LTG_SP_W-1:0]        o_setpoint,    // to analog stage
  output logic                        o_alt_active,  // alternate applied
  output logic                        o_busy,        // free train running
  output logic                        o_acq_trig,    // acquisition trigger pulse
  output logic                        o_wait_flag    // waiting_measure_trigger_flag
);
  import ltg_pkg::*;

  ltg_cfg_if cfg ();

  ltg_settings u_set (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_wr      (i_wr),
    .i_sel     (i_sel),
    .i_wdata   (i_wdata),
    .cfg       (cfg)
  );

  // cycles per period: clk*4/freq_qhz; counts kept 48 bits for the longest pulse
  function automatic logic [`LTG_CNT_W-1:0] period_cyc(input logic [`LTG_FREQ_W-1:0] f);
    period_cyc = `LTG_CNT_W'(64'(`LTG_CLK_HZ) * 64'd4 / 64'(f));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // timing decode
  wire logic [`LTG_CNT_W-1:0] per_cyc  = period_cyc(cfg.freq);
  wire logic [`LTG_CNT_W-1:0] high_cyc = `LTG_CNT_W'(64'(per_cyc) * 64'(cfg.frac) / 64'(`LTG_FRAC_FULL));
  wire logic [`LTG_CNT_W-1:0] dur_cyc  = `LTG_CNT_W'(64'(cfg.dur) * 64'(`LTG_DUR_UNIT_CYC));
  wire logic                  m_free   = (cfg.mode == `LTG_MODE_FREE);
  wire logic                  m_one    = (cfg.mode == `LTG_MODE_ONESHOT);
  wire logic                  m_swap   = (cfg.mode == `LTG_MODE_SWAP);
  wire logic                  m_table  = (cfg.mode == `LTG_MODE_TABLE);

  ltg_state_e                 st_q, st_d;
  logic [`LTG_CNT_W-1:0]      cnt_q, cnt_d;
  logic [`LTG_RPT_W-1:0]      done_q, done_d;
  logic                       swap_q, swap_d;
  logic [`LTG_MODE_W-1:0]     mode_q;

  // next state of the pulse engine; a mode change drops back to idle
  wire logic mode_chg   = (cfg.mode != mode_q);
  wire logic cnt_end    = (cnt_q <= `LTG_CNT_W'(1));
  wire logic last_per   = (cfg.rpt != '0) && (done_q + `LTG_RPT_W'(1) >= cfg.rpt);
  wire logic one_start  = m_one && i_tran_trig && (st_q == LTG_IDLE);
  wire logic free_start = m_free && i_run && (st_q == LTG_IDLE);

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    done_d = done_q;
    swap_d = swap_q;
    if (mode_chg) begin
      st_d   = LTG_IDLE;
      swap_d = 1'b0;
    end else begin
      case (st_q)
        LTG_IDLE: begin
          if (free_start) begin
            st_d   = LTG_HIGH;
            cnt_d  = high_cyc;
            done_d = '0;
          end else if (one_start) begin
            st_d  = LTG_HIGH;
            cnt_d = dur_cyc;
          end
          if (m_swap && i_tran_trig) begin
            swap_d = ~swap_q;
          end
        end
        LTG_HIGH: begin
          if (cnt_end) begin
            if (m_free) begin
              st_d  = LTG_LOW;
              cnt_d = per_cyc - high_cyc;
            end else begin
              st_d = LTG_IDLE;
            end
          end else begin
            cnt_d = cnt_q - `LTG_CNT_W'(1);
          end
        end
        LTG_LOW: begin
          if (cnt_end) begin
            done_d = done_q + `LTG_RPT_W'(1);
            if (last_per) begin
              st_d = LTG_IDLE;
            end else begin
              st_d  = LTG_HIGH;
              cnt_d = high_cyc;
            end
          end else begin
            cnt_d = cnt_q - `LTG_CNT_W'(1);
          end
        end
        default: st_d = LTG_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // setpoint select; main setpoint is only ever read here
  wire logic alt_sel = (st_q == LTG_HIGH) || (m_swap && swap_q);
  wire logic [`LTG_SP_W-1:0] sp_d = m_table ? i_table_sp : (alt_sel ? i_alt_sp : i_main_sp);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q   <= LTG_IDLE;
      cnt_q  <= '0;
      done_q <= '0;
      swap_q <= 1'b0;
      mode_q <= `LTG_MODE_RST;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      swap_q <= swap_d;
      mode_q <= cfg.mode;
    end
  end

  // registered outputs
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mode       <= `LTG_MODE_RST;
      o_setpoint   <= '0;
      o_alt_active <= 1'b0;
      o_busy       <= 1'b0;
    end else begin
      o_mode       <= cfg.mode;
      o_setpoint   <= sp_d;
      o_alt_active <= alt_sel && !m_table;
      o_busy       <= (st_d != LTG_IDLE) && m_free;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acquisition trigger gate; level crossing uses last sample of current
  logic cur_above_q;
  logic prev_valid_q;
  wire logic cur_above = (i_meas_cur >= cfg.thr);
  wire logic rise_x    = cur_above && !cur_above_q && prev_valid_q;
  wire logic fall_x    = !cur_above && cur_above_q && prev_valid_q;
  wire logic lvl_fire  = i_acq_src_lvl && (cfg.slope_fall ? fall_x : rise_x);
  wire logic src_fire  = i_acq_imm || lvl_fire || (!i_acq_src_lvl && i_acq_src_trg);
  wire logic acq_go    = src_fire && o_wait_flag;

  // arm sets the flag; a fire in the same cycle as arm only counts if the flag was already set, and then clears it
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cur_above_q  <= 1'b0;
      prev_valid_q <= 1'b0;
      o_wait_flag  <= 1'b0;
      o_acq_trig   <= 1'b0;
    end else begin
      cur_above_q  <= cur_above;
      prev_valid_q <= 1'b1;
      o_acq_trig   <= acq_go;
      if (acq_go) begin
        o_wait_flag <= 1'b0;
      end else if (i_acq_arm) begin
        o_wait_flag <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  imm_trig_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_acq_imm && o_wait_flag) |=> (o_acq_trig && !o_wait_flag)) else $error("immediate trigger lost");
  unarmed_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    !o_wait_flag |=> !o_acq_trig) else $error("trigger while unarmed");
  wait_clr_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    o_acq_trig |-> !o_wait_flag) else $error("wait flag not cleared");
  swap_flip_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (m_swap && !mode_chg && i_tran_trig && st_q == LTG_IDLE) |=> (swap_q != $past(swap_q))) else $error("swap missed");
  one_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (one_start && !mode_chg) |=> (st_q == LTG_HIGH)) else $error("one-shot not started");
  free_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (m_free && !mode_chg && st_q == LTG_HIGH && cnt_end) |=> (st_q == LTG_LOW)) else $error("free train stuck");
  table_sel_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    m_table |=> (o_setpoint == $past(i_table_sp))) else $error("table setpoint wrong");
  mode_back_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    1'b1 |=> (o_mode == $past(cfg.mode))) else $error("mode readback wrong");
  rpt_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    cfg.rpt <= `LTG_RPT_MAX) else $error("repeat total out of range");
  frac_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (cfg.frac >= `LTG_FRAC_MIN) && (cfg.frac <= `LTG_FRAC_MAX)) else $error("fraction out of range");
  freq_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (cfg.freq >= `LTG_FREQ_MIN) && (cfg.freq <= `LTG_FREQ_MAX)) else $error("frequency out of range");
  dur_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (cfg.dur >= `LTG_DUR_MIN) && (cfg.dur <= `LTG_DUR_MAX)) else $error("duration out of range");
  main_kept_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (!m_table && !alt_sel) |=> (o_setpoint == $past(i_main_sp))) else $error("main setpoint not applied");
  slope_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (lvl_fire && !cfg.slope_fall) |-> cur_above) else $error("wrong slope");
  thr_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    lvl_fire |-> (cur_above != cur_above_q)) else $error("fire without crossing");
  free_run_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (free_start && !mode_chg) |=> o_busy) else $error("free train not running");
endmodule

// File: ltg_load_model.sv
// load stage model: input current follows the applied setpoint
// assumes the system clock of the generator; no reset ordering needs
`timescale 1ns/1ps
module ltg_load_model (
  input  wire logic        i_sys_clk,  // system clock
  input  wire logic        i_arst_n,   // async reset, low
  input  wire logic [15:0] i_setpoint, // setpoint applied by the generator
  output logic      [15:0] o_meas_cur  // measured input current
);
  // one cycle of lag stands in for the stage settling, so a crossing
  // is seen a cycle after the setpoint moves, never in the same edge
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      o_meas_cur <= 16'h0000;
    else
      o_meas_cur <= i_setpoint;
  end
endmodule

// File: ltg_top_tb_top.sv
// self-checking bench for the load transient generator top
// assumes the design files and the load model are compiled before it
`timescale 1ns/1ps
`include "ltg_defines.svh"
module ltg_top_tb_top;
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        wr      = 1'b0;
  logic [2:0]  sel     = 3'h0;
  logic [31:0] wdata   = 32'h0;
  logic [15:0] main_sp = 16'h1111;
  logic [15:0] alt_sp  = 16'h2222;
  logic [15:0] tab_sp  = 16'h0010;
  logic        run     = 1'b0;
  logic        ttrig   = 1'b0;
  logic        arm     = 1'b0;
  logic        imm     = 1'b0;
  logic        srct    = 1'b0;
  logic        lvl     = 1'b0;
  wire  [15:0] cur;
  wire  [15:0] sp;
  wire  [1:0]  mode;
  wire         alt;
  wire         busy;
  wire         acq;
  wire         wflag;
  int          n_fail = 0;
  int          total_checks = 0;
  int          hc;
  int          rc;

  always #5 clk = ~clk;

  ltg_top i_dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_wr(wr), .i_sel(sel), .i_wdata(wdata),
    .i_main_sp(main_sp), .i_alt_sp(alt_sp), .i_table_sp(tab_sp), .i_tran_trig(ttrig), .i_run(run),
    .i_acq_arm(arm), .i_acq_imm(imm), .i_acq_src_lvl(lvl), .i_acq_src_trg(srct), .i_meas_cur(cur),
    .o_mode(mode), .o_setpoint(sp), .o_alt_active(alt), .o_busy(busy), .o_acq_trig(acq),
    .o_wait_flag(wflag));
  ltg_load_model i_load (.i_sys_clk(clk), .i_arst_n(rst_n), .i_setpoint(sp), .o_meas_cur(cur));

  ////////////////////////////////////////////////////////////////////////
  // shared helpers; all stimulus moves on the falling edge
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic put(input logic [2:0] s, input logic [31:0] v);
    @(negedge clk);
    wr = 1'b1;
    sel = s;
    wdata = v;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // one-cycle strobe: 0 run, 1 transient, 2 arm, 3 immediate, 4 other source
  task automatic fire(input int k);
    @(negedge clk);
    {srct, imm, arm, ttrig, run} = 5'h01 << k;
    @(negedge clk);
    {srct, imm, arm, ttrig, run} = 5'h00;
  endtask
  // counts high cycles and rising edges of the alternate flag over a window
  task automatic measure(input int w, input bit retrig);
    logic prev;
    hc = 0;
    rc = 0;
    prev = alt;
    for (int k = 0; k < w; k++) begin
      @(negedge clk);
      ttrig = retrig && (k == 100);
      hc += alt;
      rc += (alt && !prev);
      prev = alt;
    end
  endtask
  // crossing timing depends on the stage lag, so poll a short bounded span
  task automatic wait_trig(input logic exp);
    int k;
    k = 0;
    while (acq !== 1'b1 && k < 10) begin
      @(negedge clk);
      k++;
    end
    chk(acq, exp);
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    chk(mode, 2'h3);
    chk(sp, 16'h0000);
    chk({alt, busy, acq, wflag}, 4'h0);
    rst_n = 1'b1;
    tick(2);
    chk(sp, tab_sp);
    $display("test reset done");
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      put(3'h0, 32'(m));
      tick(2);
      chk(mode, m[1:0]);
    end
    tab_sp = 16'h0020;
    tick(2);
    chk(sp, tab_sp);
    $display("test modes done");
  endtask
  task automatic t_swap();
    put(3'h0, 32'h2);
    fire(1);
    tick(2);
    chk({alt, sp}, {1'b1, alt_sp});
    fire(1);
    tick(2);
    chk({alt, sp}, {1'b0, main_sp});
    $display("test swap done");
  endtask
  // zero duration clamps to one unit; a second trigger mid-pulse is ignored
  task automatic t_oneshot();
    put(3'h0, 32'h1);
    put(3'h4, 32'h0);
    fire(1);
    measure(12000, 1'b1);
    chk(hc, 10000);
    chk(rc, 1);
    $display("test one-shot done");
  endtask
  // reset settings: one period at full frequency, half high
  task automatic t_free_default();
    put(3'h0, 32'h0);
    fire(0);
    measure(13000, 1'b0);
    chk(hc, 5000);
    chk(rc, 1);
    chk(busy, 1'b0);
    put(3'h2, 32'h0);
    put(3'h1, 32'h2);
    fire(0);
    measure(23000, 1'b0);
    chk(hc, 360);
    chk(rc, 2);
    $display("test free done");
  endtask
  // half the maximum frequency doubles the period, so the high part doubles;
  // an over-range write then clamps back to the maximum for the next test
  task automatic t_freq();
    put(3'h3, 32'd20000);
    fire(0);
    measure(1000, 1'b0);
    chk(hc, 360);
    chk(busy, 1'b1);
    put(3'h0, 32'h1);
    put(3'h3, 32'h0001ffff);
    put(3'h0, 32'h0);
    tick(2);
    chk(busy, 1'b0);
    $display("test frequency done");
  endtask
  task automatic t_unlimited();
    put(3'h2, 32'd2000);
    put(3'h1, 32'h0);
    fire(0);
    measure(25000, 1'b0);
    chk(rc, 3);
    chk(busy, 1'b1);
    put(3'h0, 32'h1);
    tick(2);
    chk(busy, 1'b0);
    $display("test unlimited done");
  endtask
  task automatic t_acq();
    put(3'h0, 32'h3);
    tab_sp = 16'h0010;
    fire(3);
    chk(acq, 1'b0);
    put(3'h5, 32'h100);
    fire(2);
    chk(wflag, 1'b1);
    fire(3);
    chk({acq, wflag}, 2'b10);
    tick(1);
    chk(acq, 1'b0);
    fire(2);
    fire(4);
    chk({acq, wflag}, 2'b10);
    lvl = 1'b1;
    fire(2);
    tab_sp = 16'h0200;
    wait_trig(1'b1);
    put(3'h6, 32'h1);
    fire(2);
    tab_sp = 16'h0010;
    wait_trig(1'b1);
    fire(2);
    tab_sp = 16'h0200;
    wait_trig(1'b0);
    put(3'h6, 32'h0);
    tab_sp = 16'h0010;
    wait_trig(1'b0);
    tab_sp = 16'h00ff;
    wait_trig(1'b0);
    tab_sp = 16'h0100;
    wait_trig(1'b1);
    $display("test acquisition done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need about 75k cycles, stop a hang at 90k
  initial begin
    #900000;
    n_fail++;
    $display("watchdog expired at %0t", $time);
    end_of_test();
  end

  initial begin
    tick(20);
    t_reset();
    t_modes();
    t_swap();
    t_oneshot();
    t_free_default();
    t_freq();
    t_unlimited();
    t_acq();
    end_of_test();
  end
endmodule
